// >>> rtl/utsp_params.svh
/*
  Constants of the USB token, status and transceiver control block.
  Assumes it is included by bare name from the design files.
*/
// Notes on behaviour
// - Every accepted packet stores its 4-bit identifier; read-only, resets to zero.
// - The endpoint of the last accepted token is kept read-only, reset zero.
// - A read-only valid bit beside the stored endpoint, cleared at reset.
// - 16-bit endpoint mask; marked endpoints leave on the receive port ORed with 0x10.
// - Pulldown-disable bit turns off pulldowns on both wide ports; resets zero.
// - Auto-resume on SE0 sets the reset-cause flag; software writes zero to clear.
// - Auto-resume on K sets the resume-cause flag; software writes zero to clear.
// - Linestate changes propagate after one clock more than two to the power of a 4-bit exponent.
// - With auto-resume set the suspend controller resumes; else software polls linestate.
// - Three transceiver configuration pins follow a 3-bit writable field, reset zero.
// - Only packets addressed to the stored 7-bit device address are passed on.
`ifndef UTSP_PARAMS_SVH
`define UTSP_PARAMS_SVH

// =====================================================================
// Register offsets (byte addresses).
`define UTSP_OFF_DEVADDR 8'h08
`define UTSP_OFF_PID 8'h2c
`define UTSP_OFF_EP 8'h30
`define UTSP_OFF_EPSEL 8'h34
`define UTSP_OFF_OTGMASK 8'h38
`define UTSP_OFF_PWR 8'h3c
`define UTSP_OFF_PHY 8'h40
`define UTSP_OFF_ISTAT 8'h44
`define UTSP_OFF_IMASK 8'h48

// =====================================================================
// Field positions.
`define UTSP_EP_VALID 4
`define UTSP_EP_FLAG 5'h10
`define UTSP_PWR_VALID 8
`define UTSP_PHY_PDDIS 18
`define UTSP_PHY_RSTC 13
`define UTSP_PHY_RESC 12
`define UTSP_PHY_FILT_HI 11
`define UTSP_PHY_FILT_LO 8
`define UTSP_PHY_AUTO 7
`define UTSP_PHY_CONF_HI 6
`define UTSP_PHY_CONF_LO 4

// Interrupt status bits.
`define UTSP_IRQ_TOKEN 0
`define UTSP_IRQ_SE0 1
`define UTSP_IRQ_K 2
`define UTSP_IRQ_LINE 3
`define UTSP_IRQ_W 4

// =====================================================================
// Reset values and linestate codes.
`define UTSP_RST_ZERO 32'h0000_0000
`define UTSP_LS_SE0 2'h0
`define UTSP_LS_K 2'h2

`endif

// >>> rtl/utsp_pkg.sv
/*
  Types of the USB token, status and transceiver control block.
  Assumes nothing of its surroundings.
*/
package utsp_pkg;

  // =====================================================================
  // Suspend controller states, one-hot.
  typedef enum logic [2:0] {
    UTSP_AWAKE = 3'b001,
    UTSP_SLEEP = 3'b010,
    UTSP_WOKEN = 3'b100
  } utsp_susp_t;

endpackage : utsp_pkg

// >>> rtl/utsp_linefilt.sv
/*
  Linestate filter: a change is passed on only once it has stood still.
  Assumes a synchronous linestate input and a clock enable from above.
*/
`timescale 1ns/10ps
`include "utsp_params.svh"

module utsp_linefilt #(
  parameter int W = 2,
  parameter int EXPW = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [EXPW-1:0] exp_i,
  input wire logic [W-1:0] line_i,
  output logic [W-1:0] line_o
);

  localparam int CW = (1 << EXPW) + 1;

  logic [W-1:0] cand_ff;
  logic [W-1:0] out_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] limit;

  // Count of clocks a new level must stand before it passes.
  assign limit = CW'(1) << exp_i;
  assign line_o = out_ff;

  // =====================================================================
  // Any bounce restarts the wait, so glitches never reach the output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cand_ff <= '0;
      out_ff <= '0;
      cnt_ff <= '0;
    end else if (ce_i) begin
      if (line_i != cand_ff) begin
        cand_ff <= line_i;
        cnt_ff <= CW'(1);
      end else if (cand_ff != out_ff) begin
        if (cnt_ff >= limit) begin
          out_ff <= cand_ff;
        end else begin
          cnt_ff <= cnt_ff + CW'(1);
        end
      end
    end
  end

endmodule : utsp_linefilt

// >>> rtl/utsp_top.sv
/*
  USB token status and transceiver control block with a Wishbone slave.
  Assumes a receive decoder that presents one-cycle packet strobes, and a
  transceiver linestate synchronous to clk_i.
*/
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "utsp_params.svh"

module utsp_top
  import utsp_pkg::*;
#(
  parameter int EPN = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive decoder side.
  input wire logic rx_pkt_i,
  input wire logic rx_token_i,
  input wire logic [3:0] rx_pid_i,
  input wire logic [6:0] rx_addr_i,
  input wire logic [3:0] rx_endp_i,
  output logic [4:0] rx_ep_o,
  output logic rx_ep_valid_o,
  // Transceiver side.
  input wire logic [1:0] linestate_i,
  input wire logic suspend_i,
  output logic [1:0] linestate_filt_o,
  output logic resume_o,
  output logic wide_port_a_pd_dis_o,
  output logic wide_port_b_pd_dis_o,
  output logic [2:0] transceiver_config_pins_o,
  output logic [31:0] otg_flag_mask_o,
  output logic [8:0] power_signal_word_o,
  output logic irq_o
);

  // =====================================================================
  // Register state.
  logic [6:0] dev_addr_ff;
  logic [3:0] pid_ff;
  logic [3:0] ep_ff;
  logic ep_valid_ff;
  logic [EPN-1:0] ep_sel_ff;
  logic [31:0] otg_mask_ff;
  logic [8:0] pwr_ff;
  logic pd_dis_ff;
  logic rst_cause_ff;
  logic res_cause_ff;
  logic [3:0] filt_exp_ff;
  logic auto_res_ff;
  logic [2:0] conf_ff;
  logic [`UTSP_IRQ_W-1:0] istat_ff;
  logic [`UTSP_IRQ_W-1:0] imask_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [4:0] rx_ep_ff;
  logic rx_ep_valid_ff;
  logic resume_ff;
  logic [1:0] line_prev_ff;
  utsp_susp_t state_ff;
  utsp_susp_t nxt_state;

  logic req;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic pkt_ok;
  logic tok_ok;
  logic [1:0] line_filt;
  logic wake_se0;
  logic wake_k;
  logic line_chg;
  logic [`UTSP_IRQ_W-1:0] ievt;
  logic [31:0] rd_mux;

  // =====================================================================
  // Bus decode. A new request is taken only while no ack is out, so each
  // access gets exactly one ack and one write.
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;

  // Byte enables widened to a bit mask.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // Merged value used by every writable register except the status word.
  always_comb begin
    wval = (rd_mux & ~wmask) | (wb_dat_i & wmask);
  end

  // =====================================================================
  // Ack: one cycle after the request is taken, dropped the next cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= req;
    end
  end

  // Read data is registered together with the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= `UTSP_RST_ZERO;
    end else if (ce_i && req) begin
      rdat_ff <= rd_mux;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // =====================================================================
  // Read multiplexer; unused bits are zero and unmapped offsets read zero.
  always_comb begin
    rd_mux = `UTSP_RST_ZERO;
    unique case (wb_adr_i)
      `UTSP_OFF_DEVADDR: rd_mux[6:0] = dev_addr_ff;
      `UTSP_OFF_PID: rd_mux[3:0] = pid_ff;
      `UTSP_OFF_EP: begin
        rd_mux[3:0] = ep_ff;
        rd_mux[`UTSP_EP_VALID] = ep_valid_ff;
      end
      `UTSP_OFF_EPSEL: rd_mux[EPN-1:0] = ep_sel_ff;
      `UTSP_OFF_OTGMASK: rd_mux = otg_mask_ff;
      `UTSP_OFF_PWR: rd_mux[8:0] = pwr_ff;
      `UTSP_OFF_PHY: begin
        rd_mux[`UTSP_PHY_PDDIS] = pd_dis_ff;
        rd_mux[`UTSP_PHY_RSTC] = rst_cause_ff;
        rd_mux[`UTSP_PHY_RESC] = res_cause_ff;
        rd_mux[`UTSP_PHY_FILT_HI:`UTSP_PHY_FILT_LO] = filt_exp_ff;
        rd_mux[`UTSP_PHY_AUTO] = auto_res_ff;
        rd_mux[`UTSP_PHY_CONF_HI:`UTSP_PHY_CONF_LO] = conf_ff;
      end
      `UTSP_OFF_ISTAT: rd_mux[`UTSP_IRQ_W-1:0] = istat_ff;
      `UTSP_OFF_IMASK: rd_mux[`UTSP_IRQ_W-1:0] = imask_ff;
      default: rd_mux = `UTSP_RST_ZERO;
    endcase
  end

  // =====================================================================
  // Device address register; steers which packets are accepted.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_addr_ff <= '0;
    end else if (ce_i && wr && wb_adr_i == `UTSP_OFF_DEVADDR) begin
      dev_addr_ff <= wval[6:0];
    end
  end

  // Packets to other addresses are dropped before any capture.
  assign pkt_ok = rx_pkt_i & (rx_addr_i == dev_addr_ff);
  assign tok_ok = pkt_ok & rx_token_i;

  // =====================================================================
  // Identifier capture on every accepted packet.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pid_ff <= '0;
    end else if (ce_i && pkt_ok) begin
      pid_ff <= rx_pid_i;
    end
  end

  // Endpoint capture on accepted tokens; valid stays up once set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep_ff <= '0;
      ep_valid_ff <= 1'b0;
    end else if (ce_i && tok_ok) begin
      ep_ff <= rx_endp_i;
      ep_valid_ff <= 1'b1;
    end
  end

  // =====================================================================
  // Endpoint marking register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep_sel_ff <= '0;
    end else if (ce_i && wr && wb_adr_i == `UTSP_OFF_EPSEL) begin
      ep_sel_ff <= wval[EPN-1:0];
    end
  end

  // Receive port: endpoint with the mark bit ORed in for selected ones.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ep_ff <= '0;
      rx_ep_valid_ff <= 1'b0;
    end else if (ce_i) begin
      rx_ep_valid_ff <= tok_ok;
      if (tok_ok) begin
        rx_ep_ff <= {1'b0, rx_endp_i}
          | (ep_sel_ff[rx_endp_i] ? `UTSP_EP_FLAG : 5'h00);
      end
    end
  end

  assign rx_ep_o = rx_ep_ff;
  assign rx_ep_valid_o = rx_ep_valid_ff;

  // =====================================================================
  // Plain data registers: flag mask and power signalling word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      otg_mask_ff <= `UTSP_RST_ZERO;
      pwr_ff <= '0;
    end else if (ce_i && wr) begin
      if (wb_adr_i == `UTSP_OFF_OTGMASK) begin
        otg_mask_ff <= wval;
      end
      if (wb_adr_i == `UTSP_OFF_PWR) begin
        pwr_ff <= wval[`UTSP_PWR_VALID:0];
      end
    end
  end

  assign otg_flag_mask_o = otg_mask_ff;
  assign power_signal_word_o = pwr_ff;

  // =====================================================================
  // Transceiver control fields written by software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_dis_ff <= 1'b0;
      filt_exp_ff <= '0;
      auto_res_ff <= 1'b0;
      conf_ff <= '0;
    end else if (ce_i && wr && wb_adr_i == `UTSP_OFF_PHY) begin
      pd_dis_ff <= wval[`UTSP_PHY_PDDIS];
      filt_exp_ff <= wval[`UTSP_PHY_FILT_HI:`UTSP_PHY_FILT_LO];
      auto_res_ff <= wval[`UTSP_PHY_AUTO];
      conf_ff <= wval[`UTSP_PHY_CONF_HI:`UTSP_PHY_CONF_LO];
    end
  end

  assign wide_port_a_pd_dis_o = pd_dis_ff;
  assign wide_port_b_pd_dis_o = pd_dis_ff;
  assign transceiver_config_pins_o = conf_ff;

  // =====================================================================
  // Linestate filter with the programmed exponent.
  utsp_linefilt #(
    .W(2),
    .EXPW(4)
  ) u_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .exp_i(filt_exp_ff),
    .line_i(linestate_i),
    .line_o(line_filt)
  );

  // Filtered linestate is what software polls without auto-resume.
  assign linestate_filt_o = line_filt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_prev_ff <= '0;
    end else if (ce_i) begin
      line_prev_ff <= line_filt;
    end
  end

  assign line_chg = line_prev_ff != line_filt;

  // =====================================================================
  // Suspend controller: watches the line only in SLEEP, which is entered only with auto-resume on.
  assign wake_se0 = (state_ff == UTSP_SLEEP) && line_filt == `UTSP_LS_SE0;
  assign wake_k = (state_ff == UTSP_SLEEP) && line_filt == `UTSP_LS_K;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      UTSP_AWAKE: begin
        if (suspend_i && auto_res_ff) begin
          nxt_state = UTSP_SLEEP;
        end
      end
      UTSP_SLEEP: begin
        if (!auto_res_ff) begin
          nxt_state = UTSP_AWAKE;
        end else if (wake_se0 || wake_k) begin
          nxt_state = UTSP_WOKEN;
        end
      end
      UTSP_WOKEN: begin
        if (!suspend_i) begin
          nxt_state = UTSP_AWAKE;
        end
      end
      default: nxt_state = UTSP_AWAKE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= UTSP_AWAKE;
      resume_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      resume_ff <= wake_se0 | wake_k;
    end
  end

  assign resume_o = resume_ff;

  // =====================================================================
  // Cause flags: cleared by writing zero; a wake in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cause_ff <= 1'b0;
      res_cause_ff <= 1'b0;
    end else if (ce_i) begin
      if (wake_se0) begin
        rst_cause_ff <= 1'b1;
      end else if (wr && wb_adr_i == `UTSP_OFF_PHY && wb_sel_i[1]
                   && !wb_dat_i[`UTSP_PHY_RSTC]) begin
        rst_cause_ff <= 1'b0;
      end
      if (wake_k) begin
        res_cause_ff <= 1'b1;
      end else if (wr && wb_adr_i == `UTSP_OFF_PHY && wb_sel_i[1]
                   && !wb_dat_i[`UTSP_PHY_RESC]) begin
        res_cause_ff <= 1'b0;
      end
    end
  end

  // =====================================================================
  // Interrupt events, sticky status with write-one-to-clear, and mask.
  always_comb begin
    ievt = '0;
    ievt[`UTSP_IRQ_TOKEN] = tok_ok;
    ievt[`UTSP_IRQ_SE0] = wake_se0;
    ievt[`UTSP_IRQ_K] = wake_k;
    ievt[`UTSP_IRQ_LINE] = line_chg;
  end

  // An event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_ff <= '0;
    end else if (ce_i) begin
      if (wr && wb_adr_i == `UTSP_OFF_ISTAT) begin
        istat_ff <= (istat_ff & ~(wb_dat_i[`UTSP_IRQ_W-1:0]
          & wmask[`UTSP_IRQ_W-1:0])) | ievt;
      end else begin
        istat_ff <= istat_ff | ievt;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imask_ff <= '0;
    end else if (ce_i && wr && wb_adr_i == `UTSP_OFF_IMASK) begin
      imask_ff <= wval[`UTSP_IRQ_W-1:0];
    end
  end

  // Level output, high while any unmasked status bit stands.
  assign irq_o = |(istat_ff & imask_ff);

endmodule : utsp_top

// >>> sim/utsp_monitor.sv
/*
  Checker of the token status block, bound to its top module.
  Assumes only the top module's ports, one clock and a synchronous reset.
*/
`timescale 1ns/10ps
module utsp_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic rx_pkt_i,
  input wire logic rx_token_i,
  input wire logic [3:0] rx_endp_i,
  input wire logic [4:0] rx_ep_o,
  input wire logic rx_ep_valid_o,
  input wire logic [1:0] linestate_i,
  input wire logic [1:0] linestate_filt_o,
  input wire logic suspend_i,
  input wire logic resume_o,
  input wire logic wide_port_a_pd_dis_o,
  input wire logic wide_port_b_pd_dis_o,
  input wire logic [2:0] transceiver_config_pins_o
);
  // =====================================================================
  // A write request to the transceiver control word seen at this edge, also in its ack cycle.
  wire logic wr_phy = wb_cyc_i && wb_stb_i && wb_we_i && ce_i && wb_adr_i == 8'h40;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // =====================================================================
  // Every request is answered one cycle later, by a single pulse.
  bus_answer_a:
    assert property (wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer late or stretched");
  ep_cause_a:
    assert property (rx_ep_valid_o |-> $past(rx_pkt_i && rx_token_i)
      && rx_ep_o[3:0] == $past(rx_endp_i)) else $error("endpoint pulse without token");
  pd_pair_a:
    assert property (wide_port_a_pd_dis_o == wide_port_b_pd_dis_o)
    else $error("pulldown controls differ");
  pd_write_a:
    assert property ($changed(wide_port_a_pd_dis_o) |-> $past(wr_phy))
    else $error("pulldown control moved without a write");
  pins_write_a:
    assert property ($changed(transceiver_config_pins_o) |-> $past(wr_phy))
    else $error("config pins moved without a write");
  filt_stable_a:
    assert property ($changed(linestate_filt_o) |-> $past(linestate_i) == linestate_filt_o
      && $past(linestate_i, 2) == linestate_filt_o) else $error("unsettled linestate passed");
  wake_kind_a:
    assert property (resume_o |-> suspend_i && linestate_filt_o inside {2'h0, 2'h2})
    else $error("wake without SE0 or K");
  wake_pulse_a:
    assert property ($rose(resume_o) |=> !resume_o) else $error("wake pulse stretched");

  // Main scenarios reached.
  cover property (rx_ep_valid_o && rx_ep_o[4]);
  cover property (resume_o && linestate_filt_o == 2'h0);
  cover property ($changed(linestate_filt_o));
endmodule : utsp_monitor

bind utsp_top utsp_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .rx_pkt_i(rx_pkt_i), .rx_token_i(rx_token_i), .rx_endp_i(rx_endp_i),
  .rx_ep_o(rx_ep_o), .rx_ep_valid_o(rx_ep_valid_o), .linestate_i(linestate_i),
  .linestate_filt_o(linestate_filt_o), .suspend_i(suspend_i), .resume_o(resume_o),
  .wide_port_a_pd_dis_o(wide_port_a_pd_dis_o), .wide_port_b_pd_dis_o(wide_port_b_pd_dis_o),
  .transceiver_config_pins_o(transceiver_config_pins_o));

// >>> sim/utsp_phy_model.sv
/*
  Model of the transceiver and receive decoder facing the block.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/10ps
module utsp_phy_model (
  input wire logic clk_i,
  output logic rx_pkt_o,
  output logic rx_token_o,
  output logic [3:0] rx_pid_o,
  output logic [6:0] rx_addr_o,
  output logic [3:0] rx_endp_o,
  output logic [1:0] linestate_o,
  output logic suspend_o
);
  // =====================================================================
  // Idle bus: line in J, awake, no packet.
  initial begin
    rx_pkt_o = 1'b0;
    rx_token_o = 1'b0;
    rx_pid_o = 4'h0;
    rx_addr_o = 7'h00;
    rx_endp_o = 4'h0;
    linestate_o = 2'h1;
    suspend_o = 1'b0;
  end

  // One packet strobe; the fields are inverted after it so stale values never pass.
  task send(input logic tok, input logic [3:0] pid, input logic [6:0] a, input logic [3:0] ep);
    @(posedge clk_i);
    rx_pkt_o <= 1'b1;
    rx_token_o <= tok;
    rx_pid_o <= pid;
    rx_addr_o <= a;
    rx_endp_o <= ep;
    @(posedge clk_i);
    rx_pkt_o <= 1'b0;
    rx_token_o <= ~tok;
    rx_pid_o <= ~pid;
    rx_addr_o <= ~a;
    rx_endp_o <= ~ep;
  endtask : send

  // Line state is held until the next call, as a real bus holds its signalling.
  task line(input logic [1:0] v);
    @(posedge clk_i);
    linestate_o <= v;
  endtask : line

  task susp(input logic s);
    @(posedge clk_i);
    suspend_o <= s;
  endtask : susp
endmodule : utsp_phy_model

// >>> sim/tb_top.sv
/*
  Self-checking bench of the token status block.
  Assumes the phy model on the far side and the bound checker.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, otg_flag_mask_o;
  logic wb_ack_o, rx_pkt_i, rx_token_i, rx_ep_valid_o, suspend_i, resume_o, irq_o;
  logic [3:0] rx_pid_i, rx_endp_i;
  logic [6:0] rx_addr_i;
  logic [4:0] rx_ep_o, ep_seen;
  logic [1:0] linestate_i, linestate_filt_o;
  logic wide_port_a_pd_dis_o, wide_port_b_pd_dis_o;
  logic [2:0] transceiver_config_pins_o;
  logic [8:0] power_signal_word_o;
  logic [31:0] q;
  int err_count = 0;
  int n_tests = 0;
  int ep_cnt = 0;
  int res_cnt = 0;
  int cyc_cnt = 0;

  utsp_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_pkt_i(rx_pkt_i),
    .rx_token_i(rx_token_i), .rx_pid_i(rx_pid_i), .rx_addr_i(rx_addr_i),
    .rx_endp_i(rx_endp_i), .rx_ep_o(rx_ep_o), .rx_ep_valid_o(rx_ep_valid_o),
    .linestate_i(linestate_i), .suspend_i(suspend_i), .linestate_filt_o(linestate_filt_o),
    .resume_o(resume_o), .wide_port_a_pd_dis_o(wide_port_a_pd_dis_o),
    .wide_port_b_pd_dis_o(wide_port_b_pd_dis_o),
    .transceiver_config_pins_o(transceiver_config_pins_o),
    .otg_flag_mask_o(otg_flag_mask_o), .power_signal_word_o(power_signal_word_o),
    .irq_o(irq_o));
  utsp_phy_model phy (.clk_i(clk_i), .rx_pkt_o(rx_pkt_i), .rx_token_o(rx_token_i),
    .rx_pid_o(rx_pid_i), .rx_addr_o(rx_addr_i), .rx_endp_o(rx_endp_i),
    .linestate_o(linestate_i), .suspend_o(suspend_i));

  // =====================================================================
  // Clock, pulse recorders and the hang guard.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (rx_ep_valid_o) begin
      ep_seen <= rx_ep_o;
      ep_cnt <= ep_cnt + 1;
    end
    if (resume_o) res_cnt <= res_cnt + 1;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      err_count++;
      final_report;
    end
  end

  // =====================================================================
  // Shared tasks.
  task final_report;
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic cycle: held until ack is sampled high, then released.
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) err_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask : rd_chk

  task settle(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : settle

  task wait_res(input int n0);
    int n;
    n = 0;
    while (res_cnt == n0 && n < 30) begin
      @(posedge clk_i);
      n++;
    end
    chk("wake pulse", res_cnt, n0 + 1);
  endtask : wait_res

  // =====================================================================
  // Scenarios.
  task t_reset;
    logic [7:0] offs [9] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'h50};
    // The filtered line leaves its reset level for the idle J just after reset,
    // which is a filtered change, so the change bit of the status word stands.
    foreach (offs[i]) rd_chk("reset value", offs[i], offs[i] == 8'h44 ? 32'h8 : 32'h0);
  endtask : t_reset

  task t_tokens;
    wb(1'b1, 8'h08, 32'h5);
    wb(1'b1, 8'h34, 32'hffff_0008);
    rd_chk("endpoint select", 8'h34, 32'h0000_0008);
    phy.send(1'b1, 4'hd, 7'h05, 4'h3);
    settle(3);
    chk("marked endpoint", ep_seen, 5'h13);
    rd_chk("ident", 8'h2c, 32'hd);
    rd_chk("endpoint", 8'h30, 32'h13);
    phy.send(1'b1, 4'h9, 7'h05, 4'h2);
    phy.send(1'b0, 4'h3, 7'h05, 4'h7);
    phy.send(1'b1, 4'h1, 7'h06, 4'h5);
    settle(3);
    chk("plain endpoint", ep_seen, 5'h02);
    chk("accepted tokens", ep_cnt, 2);
    rd_chk("ident last", 8'h2c, 32'h3);
    rd_chk("endpoint last", 8'h30, 32'h12);
  endtask : t_tokens

  // Byte enables merge into the old word; a low clock enable freezes capture.
  task t_regs;
    wb(1'b1, 8'h38, 32'ha5c3_0f96);
    rd_chk("flag mask", 8'h38, 32'ha5c3_0f96);
    chk("flag mask pins", otg_flag_mask_o, 32'ha5c3_0f96);
    wb_sel_i <= 4'h1;
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    chk("power low byte", power_signal_word_o, 32'h0ff);
    wb_sel_i <= 4'h2;
    wb(1'b1, 8'h3c, 32'hffff_ff00);
    wb_sel_i <= 4'hf;
    rd_chk("power word", 8'h3c, 32'h1ff);
    ce_i <= 1'b0;
    phy.send(1'b1, 4'h6, 7'h05, 4'h1);
    ce_i <= 1'b1;
    settle(2);
    chk("frozen token", ep_cnt, 2);
    rd_chk("frozen ident", 8'h2c, 32'h3);
  endtask : t_regs

  task t_phy;
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rd_chk("phy control", 8'h40, 32'h0004_0ff0);
    settle(1);
    chk("pins all", {wide_port_a_pd_dis_o, wide_port_b_pd_dis_o, transceiver_config_pins_o},
      5'h1f);
    wb(1'b1, 8'h40, 32'h0000_0050);
    settle(1);
    chk("pins five", {wide_port_a_pd_dis_o, wide_port_b_pd_dis_o, transceiver_config_pins_o},
      5'h05);
  endtask : t_phy

  task t_filter;
    int n;
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'h40, i ? 32'h300 : 32'h0);
      phy.line(i ? 2'h1 : 2'h2);
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (linestate_filt_o !== (i ? 2'h1 : 2'h2) && n < 40);
      chk("filter delay", n, i ? 9 : 2);
    end
  endtask : t_filter

  task t_wake;
    wb(1'b1, 8'h48, 32'h6);
    wb(1'b1, 8'h40, 32'h80);
    wb(1'b1, 8'h44, 32'hf);
    phy.susp(1'b1);
    settle(2);
    phy.line(2'h2);
    wait_res(0);
    settle(1);
    chk("irq on K", irq_o, 1'b1);
    rd_chk("K cause", 8'h40, 32'h1080);
    wb(1'b1, 8'h40, 32'h80);
    rd_chk("K cleared", 8'h40, 32'h80);
    wb(1'b1, 8'h44, 32'h4);
    settle(1);
    chk("irq cleared", irq_o, 1'b0);
    phy.susp(1'b0);
    phy.line(2'h1);
    settle(4);
    phy.susp(1'b1);
    settle(2);
    phy.line(2'h0);
    wait_res(1);
    settle(1);
    chk("irq on SE0", irq_o, 1'b1);
    rd_chk("SE0 cause", 8'h40, 32'h2080);
    wb(1'b1, 8'h48, 32'h0);
    settle(1);
    chk("irq masked", irq_o, 1'b0);
    wb(1'b1, 8'h44, 32'hf);
    wb(1'b1, 8'h40, 32'h0);
    phy.susp(1'b0);
    phy.line(2'h1);
    settle(4);
    phy.susp(1'b1);
    settle(2);
    phy.line(2'h2);
    settle(12);
    chk("no auto wake", res_cnt, 2);
    chk("polled line", linestate_filt_o, 2'h2);
    rd_chk("no cause", 8'h40, 32'h0);
  endtask : t_wake

  // =====================================================================
  // Main sequence: reset held six cycles, then every scenario.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_tokens;
    t_regs;
    t_phy;
    t_filter;
    t_wake;
    final_report;
  end
endmodule : tb_top
